// ### shared/dswc_regs.svh
// Offsets, field positions, reset values and counts of the deep-sleep watchdog configuration
`ifndef DSWC_REGS_SVH
`define DSWC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DSWC_OFS_CONFIG   8'h00
`define DSWC_OFS_PROGRAM  8'h04
`define DSWC_OFS_STATUS   8'h08
`define DSWC_OFS_COUNT    8'h0c

// ****************************************************************
// Configuration word fields
// ****************************************************************
`define DSWC_CFG_WIDTH     24
`define DSWC_BIT_WDT_EN    7
`define DSWC_BIT_BOR_EN    6
`define DSWC_BIT_RTC_SEL   5
`define DSWC_BIT_WDT_SEL   4
`define DSWC_PS_MSB        3
`define DSWC_PS_LSB        0
`define DSWC_CFG_UNPROG    8'hff
`define DSWC_CFG_UPPER     16'hffff

// ****************************************************************
// Status fields
// ****************************************************************
`define DSWC_ST_PROGRAMMED 0
`define DSWC_ST_EXPIRED    1
`define DSWC_ST_RUNNING    2
`define DSWC_ST_REFUSED    3
`define DSWC_ST_BOR        4

// ****************************************************************
// Timing
// ****************************************************************
`define DSWC_PRESCALE      32
`define DSWC_BASE_TICK_MS  1
`define DSWC_PS_CODE_34S   4'h7
`define DSWC_PS_LIMIT_34S  32'h0000_8000
`define DSWC_PS_CODE_MAX   4'hf
`define DSWC_PS_LIMIT_MAX  32'h8000_0000

`endif

// ### shared/dswc_pkg.sv
// Types of the deep-sleep watchdog configuration block
package dswc_pkg;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_COUNT,
        WD_EXPIRED
    } dswc_wd_state_t;

    typedef logic [3:0] dswc_postscale_t;

endpackage

// ### rtl/dswc_prescale.sv
// Fixed divider turning reference clock ticks into base ticks
`timescale 1ns/10ps
module dswc_prescale #(
    parameter int DIV = 32
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // Tick in and out
    input  wire logic clear_i,
    input  wire logic tick_i,
    output logic      tick_o
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (clear_i) begin
            cnt_d = '0;
        end else if (tick_i) begin
            cnt_d  = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            tick_d = (cnt_q == LAST);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

    // Helper: input ticks seen since the last output tick
    logic [7:0] seen_q;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || clear_i || tick_q) begin
            seen_q <= 8'h00;
        end else if (tick_i) begin
            seen_q <= seen_q + 8'h01;
        end
    end

    a_div_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (tick_i && !clear_i && seen_q == 8'(DIV - 1)) |=> tick_o)
        else $error("prescaler missed its base tick");

    a_no_early: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (seen_q < 8'(DIV - 1) && !tick_q) |=> !tick_o)
        else $error("prescaler ticked early");

endmodule

// ### rtl/dswc_top.sv
// Deep-sleep watchdog configuration word, timeout counter and clock selects
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "dswc_regs.svh"

module dswc_top (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    // Oscillator ticks and power mode
    input  wire logic        low_power_rc_osc_tick_i,
    input  wire logic        secondary_osc_tick_i,
    input  wire logic        deep_sleep_i,
    // Watchdog, brown-out and clock outputs
    output logic             wdt_expired_o,
    output logic             brownout_protect_o,
    output logic             rtc_ref_tick_o,
    output logic             rtc_ref_clock_select_o
);

    // ****************************************************************
    // Configuration word storage
    // ****************************************************************
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic       programmed_q;
    logic       programmed_d;
    logic       refused_q;
    logic       refused_d;
    logic       prog_wr;
    logic       status_wr;

    assign prog_wr   = reg_write_i && (reg_addr_i == `DSWC_OFS_PROGRAM);
    assign status_wr = reg_write_i && (reg_addr_i == `DSWC_OFS_STATUS);

    always_comb begin
        cfg_d        = cfg_q;
        programmed_d = programmed_q;
        refused_d    = refused_q;
        if (status_wr && reg_wdata_i[`DSWC_ST_REFUSED]) begin
            refused_d = 1'b0;
        end
        if (prog_wr) begin
            if (!programmed_q) begin
                // Programming only clears bits, and only once
                cfg_d        = cfg_q & reg_wdata_i[7:0];
                programmed_d = 1'b1;
            end else begin
                refused_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg_q        <= `DSWC_CFG_UNPROG;
            programmed_q <= 1'b0;
            refused_q    <= 1'b0;
        end else begin
            cfg_q        <= cfg_d;
            programmed_q <= programmed_d;
            refused_q    <= refused_d;
        end
    end

    logic                      wdt_en;
    logic                      bor_en;
    logic                      rtc_sel;
    logic                      wdt_sel;
    dswc_pkg::dswc_postscale_t ps_code;

    assign wdt_en  = cfg_q[`DSWC_BIT_WDT_EN];
    assign bor_en  = cfg_q[`DSWC_BIT_BOR_EN];
    assign rtc_sel = cfg_q[`DSWC_BIT_RTC_SEL];
    assign wdt_sel = cfg_q[`DSWC_BIT_WDT_SEL];
    assign ps_code = cfg_q[`DSWC_PS_MSB:`DSWC_PS_LSB];

    // ****************************************************************
    // Reference clock selects and prescaler
    // ****************************************************************
    logic wdt_src_tick;
    logic base_tick;
    logic wd_clear;

    assign wdt_src_tick = wdt_sel ? low_power_rc_osc_tick_i : secondary_osc_tick_i;

    dswc_prescale #(
        .DIV(`DSWC_PRESCALE)
    ) u_prescale (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clear_i   (wd_clear),
        .tick_i    (wdt_src_tick),
        .tick_o    (base_tick)
    );

    // ****************************************************************
    // Postscale limit
    // ****************************************************************
    logic [31:0] ps_limit;
    logic [4:0]  ps_shift;

    // Divide ratio is two to the power of twice the code plus one
    assign ps_shift = {ps_code, 1'b1};
    assign ps_limit = 32'h0000_0001 << ps_shift;

    // ****************************************************************
    // Timeout counter
    // ****************************************************************
    dswc_pkg::dswc_wd_state_t state_q;
    dswc_pkg::dswc_wd_state_t state_d;
    logic [31:0]              count_q;
    logic [31:0]              count_d;
    logic                     expired_q;
    logic                     expired_d;

    // Counting only makes sense in deep sleep with the enable set
    assign wd_clear = !wdt_en || !deep_sleep_i;

    always_comb begin
        state_d   = state_q;
        count_d   = count_q;
        expired_d = expired_q;
        case (state_q)
            dswc_pkg::WD_IDLE: begin
                count_d   = '0;
                expired_d = 1'b0;
                if (!wd_clear) begin
                    state_d = dswc_pkg::WD_COUNT;
                end
            end
            dswc_pkg::WD_COUNT: begin
                if (wd_clear) begin
                    state_d = dswc_pkg::WD_IDLE;
                    count_d = '0;
                end else if (base_tick) begin
                    if (count_q == ps_limit - 32'h1) begin
                        state_d   = dswc_pkg::WD_EXPIRED;
                        expired_d = 1'b1;
                        count_d   = '0;
                    end else begin
                        count_d = count_q + 32'h1;
                    end
                end
            end
            dswc_pkg::WD_EXPIRED: begin
                if (wd_clear) begin
                    state_d   = dswc_pkg::WD_IDLE;
                    expired_d = 1'b0;
                end
            end
            default: begin
                state_d   = dswc_pkg::WD_IDLE;
                count_d   = '0;
                expired_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q   <= dswc_pkg::WD_IDLE;
            count_q   <= '0;
            expired_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            count_q   <= count_d;
            expired_q <= expired_d;
        end
    end

    assign wdt_expired_o = expired_q;

    // ****************************************************************
    // Brown-out and real-time clock outputs
    // ****************************************************************
    logic bor_q;
    logic bor_d;
    logic rtc_tick_q;
    logic rtc_tick_d;
    logic rtc_sel_q;

    always_comb begin
        // Outside deep sleep protection always stays on
        bor_d      = deep_sleep_i ? bor_en : 1'b1;
        rtc_tick_d = rtc_sel ? secondary_osc_tick_i : low_power_rc_osc_tick_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            bor_q      <= 1'b1;
            rtc_tick_q <= 1'b0;
            rtc_sel_q  <= 1'b1;
        end else begin
            bor_q      <= bor_d;
            rtc_tick_q <= rtc_tick_d;
            rtc_sel_q  <= rtc_sel;
        end
    end

    assign brownout_protect_o     = bor_q;
    assign rtc_ref_tick_o         = rtc_tick_q;
    assign rtc_ref_clock_select_o = rtc_sel_q;

    // ****************************************************************
    // Register read port
    // ****************************************************************
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  status;

    assign status = {3'h0, bor_q, refused_q, (state_q == dswc_pkg::WD_COUNT),
                     expired_q, programmed_q};

    always_comb begin
        rdata_d = '0;
        if (reg_read_i) begin
            case (reg_addr_i)
                `DSWC_OFS_CONFIG:  rdata_d = {8'h00, `DSWC_CFG_UPPER, cfg_q};
                `DSWC_OFS_STATUS:  rdata_d = {24'h0, status};
                `DSWC_OFS_COUNT:   rdata_d = count_q;
                default:           rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_last_tick;
        (state_q == dswc_pkg::WD_COUNT) && !wd_clear && base_tick
            && (count_q == ps_limit - 32'h1);
    endsequence

    sequence s_expire;
        expired_q && (state_q == dswc_pkg::WD_EXPIRED);
    endsequence

    a_upper_ones: assert property (
        (reg_read_i && reg_addr_i == `DSWC_OFS_CONFIG) |=> (reg_rdata_o[23:8] == 16'hffff))
        else $error("config upper bits not read as one");

    a_unprog_ones: assert property (
        !programmed_q |-> (cfg_q == 8'hff))
        else $error("unprogrammed config bit not one");

    a_prog_once: assert property (
        programmed_q |=> ($stable(cfg_q) && programmed_q))
        else $error("config word changed after programming");

    a_enable_gate: assert property (
        (!wdt_en) |=> (state_q == dswc_pkg::WD_IDLE) ##1 (count_q == 32'h0))
        else $error("watchdog ran while disabled");

    a_bor_deep: assert property (
        (deep_sleep_i && !bor_en) ##1 (!deep_sleep_i) |-> (brownout_protect_o == 1'b0) ##1 bor_q)
        else $error("brown-out protection wrong across sleep modes");

    a_rtc_source: assert property (
        rtc_ref_tick_o == ($past(rtc_sel) ? $past(secondary_osc_tick_i)
                                          : $past(low_power_rc_osc_tick_i)))
        else $error("real-time clock reference wrong");

    a_wdt_source: assert property (
        base_tick |-> ($past(wdt_sel) ? $past(low_power_rc_osc_tick_i)
                                      : $past(secondary_osc_tick_i)))
        else $error("watchdog reference wrong");

    a_ps_ratio: assert property (
        (ps_code == `DSWC_PS_CODE_34S) |-> (ps_limit == `DSWC_PS_LIMIT_34S))
        else $error("postscale ratio for 34 s wrong");

    a_ps_max: assert property (
        (ps_code == `DSWC_PS_CODE_MAX) |-> (ps_limit == `DSWC_PS_LIMIT_MAX))
        else $error("postscale ratio for 25.7 days wrong");

    a_expire_time: assert property (
        s_last_tick |=> s_expire ##1 (wdt_expired_o || $past(wd_clear)))
        else $error("expiry not flagged at limit");

    a_no_early_exp: assert property (
        $rose(expired_q) |-> $past(base_tick) && $past(count_q) == ps_limit - 32'h1)
        else $error("expiry flagged early");

endmodule

// ### bench/deep_sleep_watchdog_config_tb.sv
// Self-checking testbench of the deep-sleep watchdog configuration block
`timescale 1ns/10ps
`include "dswc_regs.svh"

module deep_sleep_watchdog_config_tb;

    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic        ref_clk_i               = 1'b0;
    logic        reset_i                 = 1'b1;
    logic [7:0]  reg_addr_i              = 8'h00;
    logic [31:0] reg_wdata_i             = 32'h0000_0000;
    logic        reg_write_i             = 1'b0;
    logic        reg_read_i              = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        low_power_rc_osc_tick_i = 1'b0;
    logic        secondary_osc_tick_i    = 1'b0;
    logic        deep_sleep_i            = 1'b0;
    logic        wdt_expired_o;
    logic        brownout_protect_o;
    logic        rtc_ref_tick_o;
    logic        rtc_ref_clock_select_o;
    logic [31:0] rd_data;
    int          err_total               = 0;
    int          total_checks            = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    dswc_top DUT (
        .ref_clk_i               (ref_clk_i),
        .reset_i                 (reset_i),
        .reg_addr_i              (reg_addr_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_write_i             (reg_write_i),
        .reg_read_i              (reg_read_i),
        .reg_rdata_o             (reg_rdata_o),
        .low_power_rc_osc_tick_i (low_power_rc_osc_tick_i),
        .secondary_osc_tick_i    (secondary_osc_tick_i),
        .deep_sleep_i            (deep_sleep_i),
        .wdt_expired_o           (wdt_expired_o),
        .brownout_protect_o      (brownout_protect_o),
        .rtc_ref_tick_o          (rtc_ref_tick_o),
        .rtc_ref_clock_select_o  (rtc_ref_clock_select_o)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic conclude();
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    // One-cycle oscillator pulses, one every two cycles
    task automatic ticks(input logic lp, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            if (lp) begin
                low_power_rc_osc_tick_i <= 1'b1;
            end else begin
                secondary_osc_tick_i <= 1'b1;
            end
            @(posedge ref_clk_i);
            low_power_rc_osc_tick_i <= 1'b0;
            secondary_osc_tick_i    <= 1'b0;
        end
    endtask

    task automatic rtc_tick(input logic lp, input logic exp);
        ticks(lp, 1);
        #1;
        chk1(rtc_ref_tick_o, exp);
    endtask

    task automatic do_reset();
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        wait_cyc(2);
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        wait_cyc(2);
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ffff);
        chk1(brownout_protect_o, 1'b1);
        chk1(rtc_ref_clock_select_o, 1'b1);
        reg_wr(`DSWC_OFS_CONFIG, 32'h0000_0000);
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ffff);
        reg_rd(8'h40, rd_data);
        chk(rd_data, 32'h0000_0000);
        rtc_tick(1'b1, 1'b0);
        rtc_tick(1'b0, 1'b1);
        // Enabled, no deep-sleep brown-out, low-power RC for both, code 0
        reg_wr(`DSWC_OFS_PROGRAM, 32'h0000_0090);
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ff90);
        reg_rd(`DSWC_OFS_STATUS, rd_data);
        chk(rd_data & 32'h9, 32'h1);
        reg_wr(`DSWC_OFS_PROGRAM, 32'h0000_0000);
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ff90);
        reg_rd(`DSWC_OFS_STATUS, rd_data);
        chk(rd_data & 32'h9, 32'h9);
        reg_wr(`DSWC_OFS_STATUS, 32'h0000_0008);
        reg_rd(`DSWC_OFS_STATUS, rd_data);
        chk(rd_data & 32'h8, 32'h0);
        wait_cyc(2);
        chk1(rtc_ref_clock_select_o, 1'b0);
        rtc_tick(1'b1, 1'b1);
        rtc_tick(1'b0, 1'b0);
        // Outside deep sleep ticks are ignored
        ticks(1'b1, 64);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        @(posedge ref_clk_i);
        deep_sleep_i <= 1'b1;
        wait_cyc(3);
        chk1(brownout_protect_o, 1'b0);
        ticks(1'b0, 64);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        ticks(1'b1, 32);
        wait_cyc(4);
        reg_rd(`DSWC_OFS_COUNT, rd_data);
        chk(rd_data, 32'h1);
        reg_rd(`DSWC_OFS_STATUS, rd_data);
        chk(rd_data & 32'h6, 32'h4);
        ticks(1'b1, 31);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        ticks(1'b1, 1);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b1);
        reg_rd(`DSWC_OFS_STATUS, rd_data);
        chk(rd_data & 32'h16, 32'h2);
        @(posedge ref_clk_i);
        deep_sleep_i <= 1'b0;
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        chk1(brownout_protect_o, 1'b1);
        // Erase, then secondary source for both, code 1
        do_reset();
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ffff);
        reg_wr(`DSWC_OFS_PROGRAM, 32'h0000_00a1);
        wait_cyc(2);
        chk1(rtc_ref_clock_select_o, 1'b1);
        @(posedge ref_clk_i);
        deep_sleep_i <= 1'b1;
        ticks(1'b1, 64);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        ticks(1'b0, 255);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        ticks(1'b0, 1);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b1);
        // Disabled watchdog never expires
        @(posedge ref_clk_i);
        deep_sleep_i <= 1'b0;
        do_reset();
        reg_wr(`DSWC_OFS_PROGRAM, 32'h0000_0010);
        @(posedge ref_clk_i);
        deep_sleep_i <= 1'b1;
        ticks(1'b1, 64);
        wait_cyc(4);
        chk1(wdt_expired_o, 1'b0);
        // Postscale code 7 for the 34 s timeout
        do_reset();
        reg_wr(`DSWC_OFS_PROGRAM, 32'h0000_0087);
        reg_rd(`DSWC_OFS_CONFIG, rd_data);
        chk(rd_data, 32'h00ff_ff87);
        conclude();
    end

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    initial begin
        #100000;
        err_total++;
        conclude();
    end

endmodule
